/* core/sysbit_core.sv */
// system status bits and control bits with an axi4-lite register slave
// Function
// - one-second square wave, half high half low
// - calendar fault follows clock data invalid
// - daylight bit follows summer schedule active
// - fieldbus fault follows link communication error
// - fieldbus power fault follows link power loss
// - one-cycle high pulse on stop-to-run
// - one-cycle low pulse on stop-to-run
// - decode active high while broadcast decoding
// - one pulse when decode ends without error
// - decode failure asserted on error finish
// - carrier bit mirrors modem carrier line
// - network bit follows cellular registration
// - remote bit follows remote cellular session
// - output module power bit follows supply
// - eight analog error bits, wire or range
// - inhibit keeps backlight off, else menu
// - force keeps backlight on, else menu
// - force wins over inhibit
// - screen owner: manager when high, program low
module sysbit_core #(
  parameter int HALF_CYCLES = sysbit_pkg::HALF_SECOND_CYCLES,
  parameter int N_ANALOG    = sysbit_pkg::ANALOG_INPUTS
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // axi4-lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // controller state sources
  input  wire logic                run_mode,
  input  wire logic                rtc_data_invalid,
  input  wire logic                summer_time_active,
  input  wire logic                fieldbus_comm_error,
  input  wire logic                fieldbus_power_loss,
  input  wire logic                decode_busy,
  input  wire logic                decode_done,
  input  wire logic                decode_error,
  input  wire logic                modem_carrier_line,
  input  wire logic                cell_net_access,
  input  wire logic                cell_remote_access,
  input  wire logic                out_module_supply_on,
  input  wire logic [N_ANALOG-1:0] analog_wire_broken,
  input  wire logic [N_ANALOG-1:0] analog_out_of_range,
  input  wire logic                menu_light_on,
  // status bits to the user program
  output logic                     constant_high_bit,
  output logic                     constant_low_bit,
  output logic                     one_second_square_bit,
  output logic                     calendar_fault_bit,
  output logic                     daylight_saving_bit,
  output logic                     fieldbus_comm_fault_bit,
  output logic                     fieldbus_power_fault_bit,
  output logic                     start_pulse_bit,
  output logic                     start_pulse_inverted_bit,
  output logic                     time_decode_active_bit,
  output logic                     time_decode_success_bit,
  output logic                     carrier_detect_bit,
  output logic                     network_registered_bit,
  output logic                     remote_session_bit,
  output logic                     time_decode_failure_bit,
  output logic                     output_module_power_bit,
  output logic [N_ANALOG-1:0]      analog_in_error_bits,
  // control effects
  output logic                     fieldbus_disconnect,
  output logic                     backlight_on,
  output logic                     screen_from_manager
);
  import sysbit_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [31:0]         half_cnt;
    logic                square;
    logic                run_prev;
    logic                start_pulse;
    logic                dec_ok;
    logic                dec_fail;
    logic [15:0]         status;
    logic [N_ANALOG-1:0] analog;
    logic [3:0]          ctl;
    logic                aw_held;
    logic [7:0]          aw_addr;
    logic                w_held;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } sysbit_state_t;

  sysbit_state_t st_ff;
  sysbit_state_t nxt_st;

  localparam logic [31:0] HALF_LAST = 32'(HALF_CYCLES - 1);

  // read decode, shared by the read path
  function automatic logic [32:0] sysbit_read(input logic [7:0] a, input sysbit_state_t s);
    case (a)
      STATUS_OFFSET:  sysbit_read = {1'b1, 16'h0000, s.status};
      ANALOG_OFFSET:  sysbit_read = {1'b1, 32'(s.analog)};
      CONTROL_OFFSET: sysbit_read = {1'b1, 28'h000_0000, s.ctl};
      SOURCE_OFFSET:  sysbit_read = {1'b1, 31'h0000_0000, menu_light_on};
      default:        sysbit_read = {1'b0, 32'h0000_0000};
    endcase
  endfunction

  logic run_rise;
  logic dec_ok_now;
  logic dec_fail_now;
  logic do_write;
  logic [32:0] rd;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    run_rise = run_mode & ~st_ff.run_prev;
    dec_ok_now = decode_done & ~decode_error;
    dec_fail_now = decode_done & decode_error;
    rd = sysbit_read(s_axi_araddr, st_ff);
    do_write = 1'b0;
    // half-second divider toggles the square wave
    if (st_ff.half_cnt >= HALF_LAST) begin
      nxt_st.half_cnt = 32'h0000_0000;
      nxt_st.square = ~st_ff.square;
    end else begin
      nxt_st.half_cnt = 32'(st_ff.half_cnt + 32'h0000_0001);
    end
    // edge of the mode change; held one cycle only
    nxt_st.run_prev = run_mode;
    nxt_st.start_pulse = run_rise;
    nxt_st.dec_ok = dec_ok_now;
    // failure holds until the next decode starts or succeeds
    if (dec_fail_now) begin
      nxt_st.dec_fail = 1'b1;
    end else if (decode_busy | dec_ok_now) begin
      nxt_st.dec_fail = 1'b0;
    end
    // status snapshot, one cycle behind its sources
    nxt_st.status[CONST_HIGH_POS] = 1'b1;
    nxt_st.status[CONST_LOW_POS] = 1'b0;
    nxt_st.status[SQUARE_POS] = nxt_st.square;
    nxt_st.status[CAL_FAULT_POS] = rtc_data_invalid;
    nxt_st.status[DST_POS] = summer_time_active;
    nxt_st.status[FB_COMM_POS] = fieldbus_comm_error;
    nxt_st.status[FB_PWR_POS] = fieldbus_power_loss;
    nxt_st.status[START_POS] = nxt_st.start_pulse;
    nxt_st.status[START_INV_POS] = ~nxt_st.start_pulse;
    nxt_st.status[DEC_ACTIVE_POS] = decode_busy;
    nxt_st.status[DEC_OK_POS] = nxt_st.dec_ok;
    nxt_st.status[CARRIER_POS] = modem_carrier_line;
    nxt_st.status[NET_REG_POS] = cell_net_access;
    nxt_st.status[REMOTE_POS] = cell_remote_access;
    nxt_st.status[DEC_FAIL_POS] = nxt_st.dec_fail;
    nxt_st.status[OUT_PWR_POS] = out_module_supply_on;
    nxt_st.analog = analog_wire_broken | analog_out_of_range;
    // write channels taken independently, in either order
    if (s_axi_awvalid & ~st_ff.aw_held & ~st_ff.bvalid) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid & ~st_ff.w_held & ~st_ff.bvalid) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.aw_held & st_ff.w_held & ~st_ff.bvalid) begin
      do_write = 1'b1;
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_SLVERR;
      // only the control word is writable; the rest refuse
      if (st_ff.aw_addr == CONTROL_OFFSET) begin
        nxt_st.bresp = RESP_OKAY;
        if (st_ff.w_strb[0]) begin
          nxt_st.ctl = st_ff.w_data[3:0];
        end
      end
    end
    if (st_ff.bvalid & s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // read: address taken when no answer is pending
    if (s_axi_arvalid & ~st_ff.rvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd[31:0];
      nxt_st.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (st_ff.rvalid & s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (!aresetn) begin
      nxt_st = '0;
      nxt_st.ctl = CONTROL_RESET;
      nxt_st.status[CONST_HIGH_POS] = 1'b1;
      nxt_st.status[START_INV_POS] = 1'b1;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  // bus handshakes; ready is combinational
  assign s_axi_awready = ~st_ff.aw_held & ~st_ff.bvalid;
  assign s_axi_wready  = ~st_ff.w_held & ~st_ff.bvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = ~st_ff.rvalid;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;

  // status outputs straight from the snapshot register
  assign constant_high_bit        = st_ff.status[CONST_HIGH_POS];
  assign constant_low_bit         = st_ff.status[CONST_LOW_POS];
  assign one_second_square_bit    = st_ff.status[SQUARE_POS];
  assign calendar_fault_bit       = st_ff.status[CAL_FAULT_POS];
  assign daylight_saving_bit      = st_ff.status[DST_POS];
  assign fieldbus_comm_fault_bit  = st_ff.status[FB_COMM_POS];
  assign fieldbus_power_fault_bit = st_ff.status[FB_PWR_POS];
  assign start_pulse_bit          = st_ff.status[START_POS];
  assign start_pulse_inverted_bit = st_ff.status[START_INV_POS];
  assign time_decode_active_bit   = st_ff.status[DEC_ACTIVE_POS];
  assign time_decode_success_bit  = st_ff.status[DEC_OK_POS];
  assign carrier_detect_bit       = st_ff.status[CARRIER_POS];
  assign network_registered_bit   = st_ff.status[NET_REG_POS];
  assign remote_session_bit       = st_ff.status[REMOTE_POS];
  assign time_decode_failure_bit  = st_ff.status[DEC_FAIL_POS];
  assign output_module_power_bit  = st_ff.status[OUT_PWR_POS];
  assign analog_in_error_bits     = st_ff.analog;

  // control effects; force sits before inhibit in priority
  assign fieldbus_disconnect = st_ff.ctl[FB_DISC_POS];
  assign backlight_on = st_ff.ctl[BL_FORCE_POS] | (~st_ff.ctl[BL_INHIBIT_POS] & menu_light_on);
  assign screen_from_manager = st_ff.ctl[SCREEN_OWN_POS];

  // ****************************************
  // assertions
  // ****************************************
  default clocking a_clk @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence run_edge_s;
    run_mode & ~$past(run_mode);
  endsequence

  a_const_levels: assert property (@(posedge aclk) disable iff (!aresetn)
    constant_high_bit & ~constant_low_bit) else $error("constant bits wrong");
  a_square_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff.half_cnt == HALF_LAST) |=> (one_second_square_bit != $past(one_second_square_bit)))
    else $error("square wave did not toggle");
  a_square_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff.half_cnt < HALF_LAST) |=> $stable(one_second_square_bit))
    else $error("square wave toggled early");
  a_cal_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 calendar_fault_bit == $past(rtc_data_invalid)) else $error("calendar fault lag");
  a_start_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    run_edge_s |=> start_pulse_bit & ~start_pulse_inverted_bit ##1 ~start_pulse_bit & start_pulse_inverted_bit)
    else $error("start pulse wrong");
  a_start_inv: assert property (@(posedge aclk) disable iff (!aresetn)
    start_pulse_bit != start_pulse_inverted_bit) else $error("start pulse not inverse");
  a_decode_ok: assert property (@(posedge aclk) disable iff (!aresetn)
    (decode_done & ~decode_error) |=> time_decode_success_bit) else $error("decode ok missed");
  a_decode_fail: assert property (@(posedge aclk) disable iff (!aresetn)
    (decode_done & decode_error) |=> time_decode_failure_bit) else $error("decode fail missed");
  a_analog_err: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 analog_in_error_bits == $past(analog_wire_broken | analog_out_of_range))
    else $error("analog error mismatch");
  a_force_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff.ctl[BL_FORCE_POS] |-> backlight_on) else $error("force did not light");
  a_inhibit_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff.ctl[BL_INHIBIT_POS] & ~st_ff.ctl[BL_FORCE_POS]) |-> ~backlight_on)
    else $error("inhibit ignored");
  a_ctl_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write & (st_ff.aw_addr == CONTROL_OFFSET) & st_ff.w_strb[0]) |=>
    (fieldbus_disconnect == $past(st_ff.w_data[FB_DISC_POS]))) else $error("control write lost");

  // level mirrors, one cycle behind
  a_dst_follow: assert property (
    ##1 daylight_saving_bit ==
    $past(summer_time_active))
    else $error("dst lag");

  a_fb_comm: assert property (
    ##1 fieldbus_comm_fault_bit ==
    $past(fieldbus_comm_error))
    else $error("comm lag");

  a_fb_power: assert property (
    ##1 fieldbus_power_fault_bit ==
    $past(fieldbus_power_loss))
    else $error("power lag");

  a_dec_active: assert property (
    ##1 time_decode_active_bit ==
    $past(decode_busy))
    else $error("active lag");

  a_carrier: assert property (
    ##1 carrier_detect_bit ==
    $past(modem_carrier_line))
    else $error("carrier lag");

  a_net_reg: assert property (
    ##1 network_registered_bit ==
    $past(cell_net_access))
    else $error("network lag");

  a_remote: assert property (
    ##1 remote_session_bit ==
    $past(cell_remote_access))
    else $error("remote lag");

  a_out_power: assert property (
    ##1 output_module_power_bit ==
    $past(out_module_supply_on))
    else $error("supply lag");

  // disconnect and screen owner move only on a write; backlight follows the menu light with force and inhibit clear; the low start pulse lasts one cycle
  a_disc_hold: assert property (
    ~do_write |=>
    $stable(fieldbus_disconnect))
    else $error("disconnect moved");

  a_menu_light: assert property (
    ~st_ff.ctl[BL_FORCE_POS] & ~st_ff.ctl[BL_INHIBIT_POS]
    |-> backlight_on == menu_light_on)
    else $error("menu light ignored");

  a_screen_hold: assert property (
    ~do_write |=>
    $stable(screen_from_manager))
    else $error("screen moved");

  a_low_pulse: assert property (
    ~start_pulse_inverted_bit |=>
    start_pulse_inverted_bit)
    else $error("low pulse too long");
endmodule

/* core/sysbit_pkg.sv */
// package of constants for the system and control bit block
package sysbit_pkg;
  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] STATUS_OFFSET  = 8'h00;
  localparam logic [7:0] ANALOG_OFFSET  = 8'h04;
  localparam logic [7:0] CONTROL_OFFSET = 8'h08;
  localparam logic [7:0] SOURCE_OFFSET  = 8'h0C;

  // ****************************************
  // status field positions
  // ****************************************
  localparam int CONST_HIGH_POS     = 0;
  localparam int CONST_LOW_POS      = 1;
  localparam int SQUARE_POS         = 2;
  localparam int CAL_FAULT_POS      = 3;
  localparam int DST_POS            = 4;
  localparam int FB_COMM_POS        = 5;
  localparam int FB_PWR_POS         = 6;
  localparam int START_POS          = 7;
  localparam int START_INV_POS      = 8;
  localparam int DEC_ACTIVE_POS     = 9;
  localparam int DEC_OK_POS         = 10;
  localparam int CARRIER_POS        = 11;
  localparam int NET_REG_POS        = 12;
  localparam int REMOTE_POS         = 13;
  localparam int DEC_FAIL_POS       = 14;
  localparam int OUT_PWR_POS        = 15;

  // ****************************************
  // control field positions and reset value
  // ****************************************
  localparam int FB_DISC_POS        = 0;
  localparam int BL_INHIBIT_POS     = 1;
  localparam int BL_FORCE_POS       = 2;
  localparam int SCREEN_OWN_POS     = 3;
  localparam logic [3:0] CONTROL_RESET = 4'h0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ             = 125_000_000;
  localparam int HALF_SECOND_MS     = 500;
  localparam int HALF_SECOND_CYCLES = CLK_HZ / 1000 * HALF_SECOND_MS;
  localparam int ANALOG_INPUTS      = 8;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* testbench/sysbit_core_test.sv */
// self-checking testbench of the system and control bit block
module sysbit_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sysbit_pkg::*;
  logic aclk, aresetn, run_mode, rtc_data_invalid, summer_time_active, fieldbus_comm_error;
  logic fieldbus_power_loss, decode_busy, decode_done, decode_error, modem_carrier_line;
  logic cell_net_access, cell_remote_access, out_module_supply_on, menu_light_on, dec_start, dec_bad;
  logic [7:0] s_axi_awaddr, s_axi_araddr, analog_wire_broken, analog_out_of_range, analog_in_error_bits;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic constant_high_bit, constant_low_bit, one_second_square_bit, calendar_fault_bit;
  logic daylight_saving_bit, fieldbus_comm_fault_bit, fieldbus_power_fault_bit, start_pulse_bit;
  logic start_pulse_inverted_bit, time_decode_active_bit, time_decode_success_bit, carrier_detect_bit;
  logic network_registered_bit, remote_session_bit, time_decode_failure_bit, output_module_power_bit;
  logic fieldbus_disconnect, backlight_on, screen_from_manager;
  logic [31:0] v;
  int seed = 32'h0326f368;
  int miscompares, comparisons, cycles, cnt[5], h, l, k;
  localparam int HALF = 10;
  localparam int LEN = 6;

  sysbit_core #(.HALF_CYCLES(HALF)) i_sysbit_core (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .run_mode, .rtc_data_invalid, .summer_time_active, .fieldbus_comm_error,
    .fieldbus_power_loss, .decode_busy, .decode_done, .decode_error, .modem_carrier_line, .cell_net_access,
    .cell_remote_access, .out_module_supply_on, .analog_wire_broken, .analog_out_of_range, .menu_light_on,
    .constant_high_bit, .constant_low_bit, .one_second_square_bit, .calendar_fault_bit, .daylight_saving_bit,
    .fieldbus_comm_fault_bit, .fieldbus_power_fault_bit, .start_pulse_bit, .start_pulse_inverted_bit,
    .time_decode_active_bit, .time_decode_success_bit, .carrier_detect_bit, .network_registered_bit,
    .remote_session_bit, .time_decode_failure_bit, .output_module_power_bit, .analog_in_error_bits,
    .fieldbus_disconnect, .backlight_on, .screen_from_manager);
  sysbit_src_model #(.LEN(LEN)) i_sysbit_src_model (.aclk, .aresetn, .start(dec_start), .bad(dec_bad),
    .decode_busy, .decode_done, .decode_error);

  // ****************************************
  // clock, timeout, report
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // the whole run needs a few hundred cycles; the ceiling leaves ample room
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report();
    $display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ****************************************
  // axi4-lite master, handshakes judged from the settled half cycle
  // ****************************************
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid & s_axi_awready;
      w_hs = s_axi_wvalid & s_axi_wready;
      b_hs = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid & s_axi_arready;
      r_hs = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  // counts start high, inverted low, success, active, start and inverted together
  task automatic watch(input int n);
    cnt = '{0, 0, 0, 0, 0};
    repeat (n) begin
      @(negedge aclk);
      cnt[0] += int'(start_pulse_bit === 1'b1);
      cnt[1] += int'(start_pulse_inverted_bit === 1'b0);
      cnt[2] += int'(time_decode_success_bit === 1'b1);
      cnt[3] += int'(time_decode_active_bit === 1'b1);
      cnt[4] += int'(start_pulse_bit === 1'b1 && start_pulse_inverted_bit === 1'b0);
    end
  endtask
  function automatic logic [31:0] exp_levels(input logic [31:0] s);
    return {16'h0000, s[23:16] | s[15:8], s[0], s[1], s[2], s[3], s[4], s[5], s[6], s[7]};
  endfunction
  function automatic logic exp_light(input logic [3:0] c, input logic m);
    return c[BL_FORCE_POS] | (~c[BL_INHIBIT_POS] & m);
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {aresetn, run_mode, dec_start, dec_bad, menu_light_on, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {rtc_data_invalid, summer_time_active, fieldbus_comm_error, fieldbus_power_loss} = '0;
    {modem_carrier_line, cell_net_access, cell_remote_access, out_module_supply_on} = '0;
    {analog_wire_broken, analog_out_of_range} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(STATUS_OFFSET, rd, rs);
    check("status constants", 32'h0000_0001, rd & 32'h0000_0003);
    axi_rd(CONTROL_OFFSET, rd, rs);
    check("control reset", {28'h000_0000, CONTROL_RESET}, rd);
    $display("test reset done");
    // level sources, all ones first, then random
    for (int i = 0; i < 24; i++) begin
      v = (i == 0) ? 32'hffff_ffff : $random(seed);
      @(posedge aclk);
      {analog_out_of_range, analog_wire_broken} <= v[23:8];
      {rtc_data_invalid, summer_time_active, fieldbus_comm_error, fieldbus_power_loss} <= v[7:4];
      {modem_carrier_line, cell_net_access, cell_remote_access, out_module_supply_on} <= v[3:0];
      repeat (2) @(negedge aclk);
      check("levels", exp_levels(v), {analog_in_error_bits, output_module_power_bit, remote_session_bit,
        network_registered_bit, carrier_detect_bit, fieldbus_power_fault_bit, fieldbus_comm_fault_bit,
        daylight_saving_bit, calendar_fault_bit});
      check("constant pins", 32'h0000_0001, {constant_low_bit, constant_high_bit});
      axi_rd(ANALOG_OFFSET, rd, rs);
      check("analog register", {24'h00_0000, v[23:16] | v[15:8]}, rd);
    end
    $display("test levels done");
    repeat (3) begin
      @(posedge aclk);
      run_mode <= 1'b1;
      watch(8);
      check("start pulse", 32'h0000_0001, cnt[0]);
      check("inverted pulse", 32'h0000_0001, cnt[1]);
      check("pulses together", 32'h0000_0001, cnt[4]);
      @(posedge aclk);
      run_mode <= 1'b0;
      watch(3);
    end
    $display("test start pulse done");
    repeat (2) begin
      k = 0;
      while (one_second_square_bit !== 1'b0 && k < 50) begin
        @(negedge aclk);
        k++;
      end
      while (one_second_square_bit !== 1'b1 && k < 100) begin
        @(negedge aclk);
        k++;
      end
      h = 0;
      l = 0;
      while (one_second_square_bit === 1'b1 && h < 50) begin
        @(negedge aclk);
        h++;
      end
      while (one_second_square_bit === 1'b0 && l < 50) begin
        @(negedge aclk);
        l++;
      end
      check("square high", HALF, h);
      check("square low", HALF, l);
    end
    $display("test square done");
    // good decode, bad decode, then a good one that clears the failure
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      dec_start <= 1'b1;
      dec_bad <= (i == 1);
      @(posedge aclk);
      dec_start <= 1'b0;
      watch(LEN + 8);
      check("decode active", LEN, cnt[3]);
      check("decode success", (i == 1) ? 0 : 1, cnt[2]);
      watch(4);
      check("decode failure", i == 1, time_decode_failure_bit);
    end
    $display("test decode done");
    for (int c = 0; c < 16; c++) begin
      @(posedge aclk);
      v = $random(seed);
      menu_light_on <= v[0];
      axi_wr(CONTROL_OFFSET, c, 4'hf, rs);
      check("control response", RESP_OKAY, rs);
      @(negedge aclk);
      check("disconnect", c[0], fieldbus_disconnect);
      check("backlight", exp_light(c[3:0], menu_light_on), backlight_on);
      check("screen owner", c[3], screen_from_manager);
      axi_rd(CONTROL_OFFSET, rd, rs);
      check("control readback", c, rd);
    end
    axi_wr(CONTROL_OFFSET, 32'h0000_0000, 4'he, rs);
    axi_rd(CONTROL_OFFSET, rd, rs);
    check("masked write", 32'h0000_000f, rd);
    axi_wr(8'h10, 32'h0000_0000, 4'hf, rs);
    check("unmapped write", RESP_SLVERR, rs);
    axi_rd(8'h14, rd, rs);
    check("unmapped read resp", {30'h0000_0000, RESP_SLVERR}, {30'h0000_0000, rs});
    check("unmapped read data", 32'h0000_0000, rd);
    axi_rd(SOURCE_OFFSET, rd, rs);
    check("menu source", menu_light_on, rd);
    $display("test control done");
    final_report();
  end
endmodule

/* testbench/sysbit_src_model.sv */
// partner model: long-wave time decoder feeding the decode status lines
module sysbit_src_model #(
  parameter int LEN = 6
) (
  // clock and reset
  aclk, aresetn,
  // request from the bench
  start, bad,
  // decoder status toward the block
  decode_busy, decode_done, decode_error
);
  timeunit 1ns;
  timeprecision 1ps;
  input  wire logic aclk;
  input  wire logic aresetn;
  input  wire logic start;
  input  wire logic bad;
  output logic      decode_busy;
  output logic      decode_done;
  output logic      decode_error;
  int               cnt_ff;
  logic             err_ff;
  // busy for LEN cycles, then one done cycle that carries the error flag
  always @(posedge aclk) begin
    if (!aresetn) begin
      decode_busy <= 1'b0;
      decode_done <= 1'b0;
      decode_error <= 1'b0;
      cnt_ff <= 0;
    end else begin
      decode_done <= 1'b0;
      decode_error <= ~decode_error; // meaningless outside done, so keep it moving
      if (start && !decode_busy) begin
        decode_busy <= 1'b1;
        cnt_ff <= LEN - 1;
        err_ff <= bad;
      end else if (decode_busy && cnt_ff == 0) begin
        decode_busy <= 1'b0;
        decode_done <= 1'b1;
        decode_error <= err_ff;
      end else if (decode_busy) begin
        cnt_ff <= cnt_ff - 1;
      end
    end
  end
endmodule
